// >>> scsi_rd_pkg.sv
/*
 * Constants, field layouts and carrier types shared by the long read
 * command decoder and its protection information checker.
 * Assumes a single APB clock domain and 32-bit APB data.
 */
package scsi_rd_pkg;

	// ****************************************
	// Command codes and fixed CDB values
	// ****************************************
	localparam logic [7:0] OP_RD12 = 8'hA8;
	localparam logic [7:0] OP_RD16 = 8'h88;
	localparam logic [7:0] OP_VAR = 8'h7F;
	localparam logic [7:0] ADD_LEN_32 = 8'h18;
	localparam logic [15:0] SA_RD32 = 16'h0009;
	localparam logic [2:0] PTYPE_T2 = 3'h1;
	localparam logic [2:0] RDP_NONE = 3'h0;
	localparam logic [2:0] RDP_MAXV = 3'h4;

	// ****************************************
	// Byte positions inside the CDB, and the bit offset of the protect field
	// ****************************************
	localparam int unsigned B_OPC = 0;
	localparam int unsigned B_RDP = 1;
	localparam int unsigned B_LBA12 = 2;
	localparam int unsigned B_LEN12 = 6;
	localparam int unsigned B_LEN16 = 10;
	localparam int unsigned B_ADDLEN = 7;
	localparam int unsigned B_SA = 8;
	localparam int unsigned B_RDP32 = 10;
	localparam int unsigned B_LBA32 = 12;
	localparam int unsigned B_EREF = 20;
	localparam int unsigned B_EAPP = 24;
	localparam int unsigned B_AMASK = 26;
	localparam int unsigned B_LEN32 = 28;
	localparam int unsigned RDP_LSB = 5;

	// ****************************************
	// Status, sense keys and sense codes
	// ****************************************
	localparam logic [7:0] ST_GOOD = 8'h00;
	localparam logic [7:0] ST_CHECK = 8'h02;
	localparam logic [3:0] SK_NONE = 4'h0;
	localparam logic [3:0] SK_ILLEGAL = 4'h5;
	localparam logic [3:0] SK_ABORTED = 4'hB;
	localparam logic [7:0] ASC_NONE = 8'h00;
	localparam logic [7:0] ASC_BAD_OPC = 8'h20;
	localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
	localparam logic [7:0] ASC_PI = 8'h10;
	localparam logic [7:0] ASCQ_GUARD = 8'h01;
	localparam logic [7:0] ASCQ_APP = 8'h02;
	localparam logic [7:0] ASCQ_REF = 8'h03;

	// ****************************************
	// Register map (byte addresses) and bits
	// ****************************************
	localparam int unsigned NCDBW = 8;
	localparam logic [7:0] A_CDB0 = 8'h00;
	localparam logic [7:0] A_CTRL = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;
	localparam logic [7:0] A_IRQ_ST = 8'h28;
	localparam logic [7:0] A_IRQ_MSK = 8'h2C;
	localparam logic [7:0] A_BLKCNT = 8'h30;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_PROT_EN = 1;
	localparam int unsigned CTRL_PTYPE = 2;
	localparam int unsigned CTRL_ATO = 5;
	localparam int unsigned STAT_BUSY = 31;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_CHK = 1;
	localparam int unsigned IRQ_W = 2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PI_OK = 2'b00,
		PI_GUARD = 2'b01,
		PI_APP = 2'b10,
		PI_REF = 2'b11
	} pi_err_t;

	typedef struct packed {
		logic guard_ok;
		logic [15:0] app_tag;
		logic [31:0] ref_tag;
	} pi_t;

	typedef struct packed {
		logic [7:0] status;
		logic [3:0] key;
		logic [7:0] asc;
		logic [7:0] ascq;
	} sense_t;

endpackage : scsi_rd_pkg

// >>> pi_checker.sv
/*
 * Registered check of one block's protection information against the
 * expected guard result, masked application tag and reference tag.
 * Assumes the caller presents at most one block at a time.
 */
`timescale 1ns/10ps
module pi_checker
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Block in
	input wire logic in_valid,
	input wire scsi_rd_pkg::pi_t pi,
	// Check setup
	input wire logic chk_guard,
	input wire logic chk_app,
	input wire logic chk_ref,
	input wire logic [15:0] exp_app,
	input wire logic [15:0] app_mask,
	input wire logic [31:0] exp_ref,
	// Result
	output logic res_valid,
	output scsi_rd_pkg::pi_err_t res_err
);
	import scsi_rd_pkg::*;

	logic app_bad;
	logic ref_bad;

	// Only mask bits set to one take part in the comparison
	assign app_bad = |((pi.app_tag ^ exp_app) & app_mask);
	assign ref_bad = pi.ref_tag != exp_ref;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			res_valid <= 1'b0;
			res_err <= PI_OK;
		end
		else
		begin
			res_valid <= in_valid;
			// Guard first, then application tag, then reference tag
			if (chk_guard && !pi.guard_ok)
				res_err <= PI_GUARD;
			else if (chk_app && app_bad)
				res_err <= PI_APP;
			else if (chk_ref && ref_bad)
				res_err <= PI_REF;
			else
				res_err <= PI_OK;
		end
	end

endmodule : pi_checker

// >>> scsi_long_read_cdb_decoder.sv
/*
 * Decoder and executor for 12-, 16- and 32-byte read CDBs: APB register file,
 * one-block-at-a-time media request stream and per-block protection checking.
 * Assumes media answers each block request with one blk_pi_valid pulse on pclk.
 */
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module scsi_long_read_cdb_decoder
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Media block stream
	output logic blk_req,
	output logic [63:0] blk_lba,
	output logic blk_pi_xmit,
	input wire logic blk_pi_valid,
	input wire scsi_rd_pkg::pi_t blk_pi,
	// Interrupt
	output logic irq
);
	import scsi_rd_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_DECODE = 3'b001,
		S_ISSUE = 3'b010,
		S_WAIT = 3'b011,
		S_DONE = 3'b100
	} state_t;

	// ****************************************
	// Helpers
	// ****************************************
	// Big-endian field of n bytes starting at byte pos, n at most 8
	function automatic logic [63:0] field_be(input logic [255:0] c, input int unsigned pos,
		input int unsigned n);
		logic [63:0] r;
		r = '0;
		for (int unsigned i = 0; i < 8; i++)
		begin
			if (i < n)
				r = {r[55:0], c[8*(pos+i) +: 8]};
		end
		return r;
	endfunction : field_be

	function automatic sense_t mk_sense(input logic [3:0] key, input logic [7:0] asc,
		input logic [7:0] ascq);
		sense_t s;
		s.status = (key == SK_NONE) ? ST_GOOD : ST_CHECK;
		s.key = key;
		s.asc = asc;
		s.ascq = ascq;
		return s;
	endfunction : mk_sense

	// ****************************************
	// APB register file
	// ****************************************
	logic [31:0] cdb_q [NCDBW];
	logic [255:0] cdb_flat;
	logic prot_en_q;
	logic [2:0] ptype_q;
	logic ato_q;
	logic start_q;
	logic [IRQ_W-1:0] irq_st_q;
	logic [IRQ_W-1:0] irq_msk_q;
	logic [IRQ_W-1:0] irq_set;
	logic [31:0] blk_cnt_q;
	sense_t sense_q;
	state_t state_q;
	logic busy;
	logic acc;
	logic wr;
	logic rd_hit;
	logic [31:0] rd_val;

	// Bytes of the CDB sit little-endian inside each word
	always_comb
	begin
		for (int i = 0; i < NCDBW; i++)
			cdb_flat[32*i +: 32] = cdb_q[i];
	end

	assign busy = state_q != S_IDLE;
	// One wait state: pready is raised in the second access cycle
	assign acc = psel && penable && !pready;
	assign wr = psel && penable && pready && pwrite;

	always_comb
	begin
		rd_hit = 1'b1;
		rd_val = '0;
		if (paddr < A_CTRL && paddr[1:0] == 2'b00)
			rd_val = cdb_q[paddr[4:2]];
		else
			unique case (paddr)
				A_CTRL: rd_val = {26'h0, ato_q, ptype_q, prot_en_q, 1'b0};
				A_STAT:
				begin
					rd_val = {sense_q.status, sense_q.key, sense_q.asc, sense_q.ascq, 4'h0};
					rd_val[STAT_BUSY] = busy;
				end
				A_IRQ_ST: rd_val = {30'h0, irq_st_q};
				A_IRQ_MSK: rd_val = {30'h0, irq_msk_q};
				A_BLKCNT: rd_val = blk_cnt_q;
				default: rd_hit = 1'b0;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= acc;
			prdata <= (acc && !pwrite && rd_hit) ? rd_val : 32'h0000_0000;
			pslverr <= acc && !rd_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int i = 0; i < NCDBW; i++)
				cdb_q[i] <= 32'h0000_0000;
		else if (wr && paddr < A_CTRL && paddr[1:0] == 2'b00)
			cdb_q[paddr[4:2]] <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prot_en_q <= 1'b0;
			ptype_q <= 3'h0;
			ato_q <= 1'b0;
			start_q <= 1'b0;
		end
		else
		begin
			// Start while busy is dropped so a running command is never disturbed
			start_q <= wr && paddr == A_CTRL && pwdata[CTRL_START] && !busy;
			if (wr && paddr == A_CTRL)
			begin
				prot_en_q <= pwdata[CTRL_PROT_EN];
				ptype_q <= pwdata[CTRL_PTYPE +: 3];
				ato_q <= pwdata[CTRL_ATO];
			end
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_st_q <= '0;
			irq_msk_q <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (wr && paddr == A_IRQ_MSK)
				irq_msk_q <= pwdata[IRQ_W-1:0];
			if (wr && paddr == A_IRQ_ST)
				irq_st_q <= (irq_st_q & ~pwdata[IRQ_W-1:0]) | irq_set;
			else
				irq_st_q <= irq_st_q | irq_set;
			irq <= |(irq_st_q & irq_msk_q);
		end
	end

	// ****************************************
	// CDB decode
	// ****************************************
	logic [7:0] opc;
	logic is12;
	logic is16;
	logic is32;
	logic var_opc;
	logic [2:0] rdp;
	logic [63:0] dec_lba;
	logic [31:0] dec_len;
	sense_t dec_sense;

	assign opc = cdb_flat[8*B_OPC +: 8];
	assign is12 = opc == OP_RD12;
	assign is16 = opc == OP_RD16;
	assign var_opc = opc == OP_VAR;
	assign is32 = var_opc && cdb_flat[8*B_ADDLEN +: 8] == ADD_LEN_32
		&& field_be(cdb_flat, B_SA, 2) == {48'h0, SA_RD32};
	assign rdp = is32 ? cdb_flat[8*B_RDP32+RDP_LSB +: 3] : cdb_flat[8*B_RDP+RDP_LSB +: 3];

	always_comb
	begin
		dec_lba = '0;
		dec_len = '0;
		if (is12)
		begin
			dec_lba = field_be(cdb_flat, B_LBA12, 4);
			dec_len = 32'(field_be(cdb_flat, B_LEN12, 4));
		end
		else if (is16)
		begin
			dec_lba = field_be(cdb_flat, B_LBA12, 8);
			dec_len = 32'(field_be(cdb_flat, B_LEN16, 4));
		end
		else if (is32)
		begin
			dec_lba = field_be(cdb_flat, B_LBA32, 8);
			dec_len = 32'(field_be(cdb_flat, B_LEN32, 4));
		end
	end

	always_comb
	begin
		if (!(is12 || is16 || is32))
			dec_sense = mk_sense(SK_ILLEGAL, ASC_BAD_OPC, ASC_NONE);
		else if (is32 && !(prot_en_q && ptype_q == PTYPE_T2))
			dec_sense = mk_sense(SK_ILLEGAL, ASC_BAD_OPC, ASC_NONE);
		else if (rdp > RDP_MAXV || (!prot_en_q && rdp != RDP_NONE))
			dec_sense = mk_sense(SK_ILLEGAL, ASC_BAD_FIELD, ASC_NONE);
		else
			dec_sense = mk_sense(SK_NONE, ASC_NONE, ASC_NONE);
	end

	// ****************************************
	// Command execution
	// ****************************************
	logic [31:0] left_q;
	logic [31:0] exp_ref_q;
	logic [15:0] exp_app_q;
	logic [15:0] mask_q;
	logic chk_guard_q;
	logic chk_app_q;
	logic chk_ref_q;
	logic res_valid;
	pi_err_t res_err;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= S_IDLE;
			sense_q <= '0;
			blk_req <= 1'b0;
			blk_lba <= 64'h0;
			blk_pi_xmit <= 1'b0;
			left_q <= 32'h0;
			exp_ref_q <= 32'h0;
			exp_app_q <= 16'h0;
			mask_q <= 16'h0;
			chk_guard_q <= 1'b0;
			chk_app_q <= 1'b0;
			chk_ref_q <= 1'b0;
			irq_set <= '0;
		end
		else
		begin
			blk_req <= 1'b0;
			irq_set <= '0;
			unique case (state_q)
				S_IDLE:
					if (start_q)
						state_q <= S_DECODE;
				S_DECODE:
				begin
					sense_q <= dec_sense;
					blk_lba <= dec_lba;
					left_q <= dec_len;
					blk_pi_xmit <= rdp != RDP_NONE;
					chk_guard_q <= rdp == 3'h1 || rdp == RDP_MAXV;
					chk_ref_q <= rdp == 3'h1 || rdp == 3'h2;
					// Application tag checked only by the 32-byte form with owner bit set
					chk_app_q <= is32 && ato_q && (rdp == 3'h1 || rdp == 3'h2);
					exp_ref_q <= is32 ? 32'(field_be(cdb_flat, B_EREF, 4)) : dec_lba[31:0];
					exp_app_q <= 16'(field_be(cdb_flat, B_EAPP, 2));
					mask_q <= 16'(field_be(cdb_flat, B_AMASK, 2));
					// Errors and zero length skip the block loop
					state_q <= (dec_sense.key != SK_NONE || dec_len == 32'h0) ? S_DONE : S_ISSUE;
				end
				S_ISSUE:
				begin
					blk_req <= 1'b1;
					state_q <= S_WAIT;
				end
				S_WAIT:
					if (res_valid)
					begin
						unique case (res_err)
							PI_GUARD: sense_q <= mk_sense(SK_ABORTED, ASC_PI, ASCQ_GUARD);
							PI_APP: sense_q <= mk_sense(SK_ABORTED, ASC_PI, ASCQ_APP);
							PI_REF: sense_q <= mk_sense(SK_ABORTED, ASC_PI, ASCQ_REF);
							PI_OK: sense_q <= sense_q;
						endcase
						blk_lba <= blk_lba + 64'h1;
						exp_ref_q <= exp_ref_q + 32'h1;
						left_q <= left_q - 32'h1;
						state_q <= (res_err != PI_OK || left_q == 32'h1) ? S_DONE : S_ISSUE;
					end
				S_DONE:
				begin
					irq_set[IRQ_DONE] <= 1'b1;
					irq_set[IRQ_CHK] <= sense_q.status != ST_GOOD;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Blocks whose protection check passed, for the last command
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			blk_cnt_q <= 32'h0;
		else if (state_q == S_DECODE)
			blk_cnt_q <= 32'h0;
		else if (res_valid && res_err == PI_OK)
			blk_cnt_q <= blk_cnt_q + 32'h1;
	end

	pi_checker u_pi_checker
	(
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(blk_pi_valid && state_q == S_WAIT),
		.pi(blk_pi),
		.chk_guard(chk_guard_q),
		.chk_app(chk_app_q),
		.chk_ref(chk_ref_q),
		.exp_app(exp_app_q),
		.app_mask(mask_q),
		.exp_ref(exp_ref_q),
		.res_valid(res_valid),
		.res_err(res_err)
	);

endmodule : scsi_long_read_cdb_decoder

// >>> scsi_rd_sva.sv
/*
 * Port-level checker for the long read CDB decoder.
 * Assumes one pclk domain, bound from the testbench top file.
 */
`timescale 1ns/10ps
module scsi_rd_sva
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Media stream and interrupt
	input wire logic blk_req,
	input wire logic [63:0] blk_lba,
	input wire logic blk_pi_xmit,
	input wire logic blk_pi_valid,
	input wire scsi_rd_pkg::pi_t blk_pi,
	input wire logic irq
);
	import scsi_rd_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_in_access: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside an answered access");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero while idle");
	a_req_single: assert property (blk_req |=> !blk_req [*2])
		else $error("block request repeated too soon");
	a_lba_hold: assert property (blk_req |=> $stable(blk_lba) && $stable(blk_pi_xmit))
		else $error("block address or transmit flag moved after request");
	a_gap_after_answer: assert property (blk_pi_valid |-> !blk_req ##1 !blk_req)
		else $error("next request before check result");
	a_irq_fall_cause: assert property ($fell(irq) && $past(presetn) |->
		$past(psel, 2) && $past(penable, 2) && $past(pready, 2) && $past(pwrite, 2))
		else $error("irq dropped without a register write");

	c_answer: cover property (blk_pi_valid);
	c_slverr: cover property (pslverr);
	c_irq: cover property ($rose(irq));
endmodule : scsi_rd_sva

// >>> media_model.sv
/*
 * Behavioural media side: answers each block request once, alternately
 * fast and slow, and records the last request for the testbench.
 * Assumes one outstanding request at a time.
 */
`timescale 1ns/10ps
module media_model
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Block stream
	input wire logic blk_req,
	input wire logic [63:0] blk_lba,
	input wire logic blk_pi_xmit,
	output logic blk_pi_valid,
	output scsi_rd_pkg::pi_t blk_pi,
	// Stored contents and trace
	input wire logic [31:0] ref_off,
	input wire logic [15:0] app_tag,
	input wire logic guard_ok,
	output logic [31:0] req_cnt,
	output logic [63:0] last_lba,
	output logic last_xmit
);
	import scsi_rd_pkg::*;

	logic [2:0] wait_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_q <= 3'h0;
			blk_pi_valid <= 1'b0;
			blk_pi <= '0;
			req_cnt <= 32'h0;
			last_lba <= 64'h0;
			last_xmit <= 1'b0;
		end
		else
		begin
			blk_pi_valid <= 1'b0;
			// Stale tag data toggles so a late sample never matches by luck
			blk_pi <= ~blk_pi;
			if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
			if (wait_q == 3'h1)
			begin
				blk_pi_valid <= 1'b1;
				blk_pi <= {guard_ok, app_tag, last_lba[31:0] + ref_off};
			end
			if (blk_req)
			begin
				wait_q <= req_cnt[0] ? 3'h5 : 3'h1;
				req_cnt <= req_cnt + 32'h1;
				last_lba <= blk_lba;
				last_xmit <= blk_pi_xmit;
			end
		end
	end
endmodule : media_model

// >>> scsi_long_read_cdb_decoder_test.sv
/*
 * Self-checking testbench for the long read CDB decoder.
 * Assumes the media model answers every block request.
 */
`timescale 1ns/10ps
module scsi_long_read_cdb_decoder_test;
	import scsi_rd_pkg::*;

	localparam logic [31:0] T2 = 32'h0000_0006;
	localparam logic [31:0] ATO = 32'h0000_0020;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, req_cnt, ref_off = 32'h0;
	logic pready, pslverr, blk_req, blk_pi_xmit, blk_pi_valid, irq, last_xmit;
	logic [63:0] blk_lba, last_lba;
	logic [15:0] app_tag = 16'h0;
	logic guard_ok = 1'b1;
	pi_t blk_pi;
	logic [7:0] cdb [32];
	int fails = 0, total_checks = 0;

	scsi_long_read_cdb_decoder DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .blk_req, .blk_lba, .blk_pi_xmit,
		.blk_pi_valid, .blk_pi, .irq);
	media_model u_media (.pclk, .presetn, .blk_req, .blk_lba, .blk_pi_xmit, .blk_pi_valid,
		.blk_pi, .ref_off, .app_tag, .guard_ok, .req_cnt, .last_lba, .last_xmit);

	initial
	begin
		forever #50 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle limit here: a slave that never answers is caught by the watchdog
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	function automatic logic [31:0] sw(input logic [3:0] k, input logic [7:0] c,
		input logic [7:0] q);
		return {ST_CHECK, k, c, q, 4'h0};
	endfunction : sw

	task automatic put(input int p, input int n, input logic [63:0] v);
		for (int i = 0; i < n; i++)
			cdb[p + i] = v[8 * (n - 1 - i) +: 8];
	endtask : put

	task automatic cdb_new(input logic [7:0] op, input logic [2:0] rdp);
		cdb = '{default: 8'h00};
		cdb[0] = op;
		if (op == OP_VAR)
		begin
			cdb[7] = ADD_LEN_32;
			put(8, 2, SA_RD32);
			cdb[10] = {rdp, 5'h00};
		end
		else
			cdb[1] = {rdp, 5'h00};
	endtask : cdb_new

	task automatic load_start(input logic [31:0] ctl);
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 8; i++)
			apb(1'b1, 8'(4 * i), {cdb[4*i+3], cdb[4*i+2], cdb[4*i+1], cdb[4*i]}, r, e);
		apb(1'b1, A_CTRL, ctl | 32'h1, r, e);
	endtask : load_start

	// Runs the loaded command and judges status, block count and requests
	task automatic exec(input logic [31:0] ctl, input logic [31:0] st, input int nb,
		input int nr);
		logic [31:0] r, c0;
		logic e;
		int n;
		c0 = req_cnt;
		n = 0;
		load_start(ctl);
		while (irq !== 1'b1 && n < 500)
		begin
			@(posedge pclk);
			n++;
		end
		chk("irq", 1'b1, irq);
		apb(1'b0, A_STAT, 32'h0, r, e);
		chk("status", st, r);
		apb(1'b0, A_BLKCNT, 32'h0, r, e);
		chk("blocks", nb, r);
		chk("requests", nr, req_cnt - c0);
		apb(1'b1, A_IRQ_ST, 32'h3, r, e);
		repeat (2) @(posedge pclk);
		chk("irq clear", 1'b0, irq);
	endtask : exec

	task automatic t_rd16;
		cdb_new(OP_RD16, 3'h0);
		put(2, 8, 64'h0000_0001_2345_6780);
		put(10, 4, 64'h3);
		exec(32'h0, 32'h0, 3, 3);
		chk("last lba", 64'h0000_0001_2345_6782, last_lba);
		chk("pi xmit", 1'b0, last_xmit);
	endtask : t_rd16

	task automatic t_rd12;
		cdb_new(OP_RD12, 3'h1);
		put(2, 4, 64'h1000);
		put(6, 4, 64'h2);
		exec(T2, 32'h0, 2, 2);
		chk("last lba", 64'h1001, last_lba);
		put(6, 4, 64'h0);
		exec(T2, 32'h0, 0, 0);
		cdb_new(OP_RD12, 3'h3);
		put(6, 4, 64'h1);
		exec(32'h0, sw(SK_ILLEGAL, ASC_BAD_FIELD, 8'h00), 0, 0);
		cdb_new(OP_RD12, 3'h5);
		exec(T2, sw(SK_ILLEGAL, ASC_BAD_FIELD, 8'h00), 0, 0);
	endtask : t_rd12

	task automatic t_rd32;
		cdb_new(OP_VAR, 3'h1);
		put(12, 8, 64'h50);
		put(20, 4, 64'h100);
		put(28, 4, 64'h3);
		ref_off <= 32'hB0;
		exec(T2, 32'h0, 3, 3);
		exec(32'h2, sw(SK_ILLEGAL, ASC_BAD_OPC, 8'h00), 0, 0);
		exec(32'hA, sw(SK_ILLEGAL, ASC_BAD_OPC, 8'h00), 0, 0);
		ref_off <= 32'hB1;
		exec(T2, sw(SK_ABORTED, ASC_PI, ASCQ_REF), 0, 1);
		ref_off <= 32'hB0;
		cdb[9] = 8'h08;
		exec(T2, sw(SK_ILLEGAL, ASC_BAD_OPC, 8'h00), 0, 0);
	endtask : t_rd32

	task automatic t_app;
		logic [31:0] r;
		logic e;
		cdb_new(OP_VAR, 3'h2);
		put(24, 2, 64'h1234);
		put(26, 2, 64'hFF00);
		put(28, 4, 64'h1);
		ref_off <= 32'h0;
		app_tag <= 16'h12AB;
		exec(T2 | ATO, 32'h0, 1, 1);
		chk("pi xmit", 1'b1, last_xmit);
		apb(1'b0, A_CTRL, 32'h0, r, e);
		chk("ctrl", T2 | ATO, r);
		app_tag <= 16'h13AB;
		exec(T2 | ATO, sw(SK_ABORTED, ASC_PI, ASCQ_APP), 0, 1);
		exec(T2, 32'h0, 1, 1);
		cdb_new(OP_VAR, 3'h4);
		put(28, 4, 64'h2);
		guard_ok <= 1'b0;
		exec(T2, sw(SK_ABORTED, ASC_PI, ASCQ_GUARD), 0, 1);
		guard_ok <= 1'b1;
	endtask : t_app

	task automatic t_bus;
		logic [31:0] r;
		logic e;
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk("unmapped err", 1'b1, e);
		chk("unmapped data", 32'h0, r);
		apb(1'b1, A_IRQ_MSK, 32'h0, r, e);
		cdb_new(OP_RD16, 3'h0);
		load_start(32'h0);
		repeat (30) @(posedge pclk);
		chk("masked irq", 1'b0, irq);
		apb(1'b0, A_IRQ_ST, 32'h0, r, e);
		chk("done flag", 1'b1, r[IRQ_DONE]);
		apb(1'b1, A_IRQ_ST, 32'h3, r, e);
		apb(1'b1, A_IRQ_MSK, 32'h3, r, e);
	endtask : t_bus

	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#2000000;
		fails++;
		tally_and_finish;
	end

	initial
	begin
		logic [31:0] r;
		logic e;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, A_IRQ_MSK, 32'h3, r, e);
		t_bus;
		t_rd16;
		t_rd12;
		t_rd32;
		t_app;
		tally_and_finish;
	end
endmodule : scsi_long_read_cdb_decoder_test

bind scsi_long_read_cdb_decoder scsi_rd_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .blk_req, .blk_lba, .blk_pi_xmit,
	.blk_pi_valid, .blk_pi, .irq);
